/* File: core/gped_map.vh */
`ifndef GPED_MAP_VH
`define GPED_MAP_VH
`define GPED_PIN_ENABLE_ADDR 32'h01B00000
`define GPED_PIN_DIRECTION_ADDR 32'h01B00004
`define GPED_PIN_VALUE_ADDR 32'h01B00008
`define GPED_PIN_OUT_ADDR 32'h01B0000C
`define GPED_ENABLE_RESET 16'h00F9
`define GPED_DIRECTION_RESET 16'h0000
`define GPED_PIN_COUNT 16
`define GPED_RESERVED_ZERO 16'h0000
`endif

/* File: core/gped_pin_cell.v */
`timescale 1ns/1ps
`include "gped_map.vh"
module gped_pin_cell (
    enable_bit,
    direction_bit,
    out_bit,
    pin_in,
    pin_out,
    pin_oe,
    sample
);
    input wire enable_bit;
    input wire direction_bit;
    input wire out_bit;
    input wire pin_in;
    output wire pin_out;
    output wire pin_oe;
    output wire sample;
    // direction is ignored unless the pin is enabled
    assign pin_oe = enable_bit & direction_bit; // [R2] [R3] [R4]
    assign pin_out = pin_oe & out_bit;
    // disabled pins read zero so software never sees foreign traffic
    assign sample = enable_bit & pin_in; // [R2]
endmodule // gped_pin_cell

/* File: core/gped_port.v */
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "gped_map.vh"
// Summary of operation
// [R1] sixteen pins 15..0, enable and direction bit at the pin's position
// [R2] a pin is general purpose only while its enable bit is 1
// [R3] enabled pin: direction 0 means input, 1 means output drive
// [R4] direction bits of disabled pins have no effect on the pin
// [R5] reset clears all direction bits, every pin starts as input
// [R6] enable resets with bits 7,6,5,4,3,0 set, others clear
// [R7] enable register at byte 0x01B00000, read and write
// [R8] direction register at byte 0x01B00004, read and write
// [R9] bits 31..16 of both registers read zero, writes ignored
module gped_port #(
    parameter PINS = `GPED_PIN_COUNT
) (
    clk,
    rst,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_dat_i,
    wb_sel_i,
    wb_dat_o,
    wb_ack_o,
    wb_err_o,
    general_pins_in,
    general_pins_out,
    general_pins_oe
);
    input wire clk;
    input wire rst;
    input wire wb_cyc_i;
    input wire wb_stb_i;
    input wire wb_we_i;
    input wire [31:0] wb_adr_i;
    input wire [31:0] wb_dat_i;
    input wire [3:0] wb_sel_i;
    output reg [31:0] wb_dat_o;
    output reg wb_ack_o;
    output reg wb_err_o;
    input wire [PINS-1:0] general_pins_in;
    output wire [PINS-1:0] general_pins_out;
    output wire [PINS-1:0] general_pins_oe;

    reg [15:0] enable_q;
    reg [15:0] direction_q;
    reg [15:0] out_q;
    wire [PINS-1:0] sample;
    wire req;
    wire hit_en;
    wire hit_dir;
    wire hit_val;
    wire hit_out;
    wire hit;
    wire [15:0] lane_mask;
    reg [31:0] rdata_d;
    reg [15:0] enable_d;
    reg [15:0] direction_d;
    reg [15:0] out_d;
    reg [31:0] dat_d;
    reg [2:0] state_q;
    reg [2:0] state_d;
    wire wr_req;
    wire rd_req;
    wire wr_en;
    wire wr_dir;
    wire wr_out;
    wire [15:0] wdata;

    // answer states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ACK = 3'b010;
    localparam [2:0] ST_ERR = 3'b100;

    // one answer per request; ack drops for a cycle between requests
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit_en = wb_adr_i == `GPED_PIN_ENABLE_ADDR; // [R7]
    assign hit_dir = wb_adr_i == `GPED_PIN_DIRECTION_ADDR; // [R8]
    assign hit_val = wb_adr_i == `GPED_PIN_VALUE_ADDR;
    assign hit_out = wb_adr_i == `GPED_PIN_OUT_ADDR;
    assign hit = hit_en | hit_dir | hit_val | hit_out;
    // only the two low byte lanes hold bits
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}; // [R9]

    // a refused address never writes; it only earns an error pulse
    assign wr_req = req & wb_we_i & hit;
    assign rd_req = req & ~wb_we_i & hit;
    assign wr_en = wr_req & hit_en; // [R7]
    assign wr_dir = wr_req & hit_dir; // [R8]
    assign wr_out = wr_req & hit_out;
    // upper lanes never reach a register bit
    assign wdata = wb_dat_i[15:0] & lane_mask; // [R9]

    always @* begin
        rdata_d = 32'h00000000;
        if (hit_en) begin
            rdata_d = {`GPED_RESERVED_ZERO, enable_q}; // [R7] [R9]
        end else if (hit_dir) begin
            rdata_d = {`GPED_RESERVED_ZERO, direction_q}; // [R8] [R9]
        end else if (hit_val) begin
            rdata_d = {`GPED_RESERVED_ZERO, sample};
        end else if (hit_out) begin
            rdata_d = {`GPED_RESERVED_ZERO, out_q};
        end
    end

    // next values; a lane that is not selected keeps its old bits
    always @* begin
        enable_d = enable_q;
        direction_d = direction_q;
        out_d = out_q;
        if (wr_en) begin
            enable_d = (enable_q & ~lane_mask) | wdata; // [R7] [R9]
        end
        if (wr_dir) begin
            direction_d = (direction_q & ~lane_mask) | wdata; // [R8] [R9]
        end
        if (wr_out) begin
            out_d = (out_q & ~lane_mask) | wdata;
        end
    end

    // every answer lasts one cycle and is followed by a quiet cycle,
    // so a master that holds stb after ack is not taken twice
    always @* begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE: begin
                if (req & hit) begin
                    state_d = ST_ACK;
                end else if (req) begin
                    state_d = ST_ERR;
                end
            end
            ST_ACK: begin
                state_d = ST_IDLE;
            end
            ST_ERR: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // handshake pulses come straight from the state register
    always @* begin
        wb_ack_o = state_q == ST_ACK;
        wb_err_o = state_q == ST_ERR;
    end

    // read data only on a mapped read; zero keeps the bus quiet otherwise
    always @* begin
        dat_d = 32'h00000000;
        if (rd_req) begin
            dat_d = rdata_d;
        end
    end

    // reset leaves the power-on pin set enabled
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= `GPED_ENABLE_RESET; // [R6]
        end else begin
            enable_q <= enable_d;
        end
    end

    // reset turns every pin into an input
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            direction_q <= `GPED_DIRECTION_RESET; // [R5]
        end else begin
            direction_q <= direction_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= `GPED_RESERVED_ZERO;
        end else begin
            out_q <= out_d;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered data, valid in the cycle of ack
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= dat_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin // [R1]
            gped_pin_cell u_cell (
                .enable_bit(enable_q[i]),
                .direction_bit(direction_q[i]),
                .out_bit(out_q[i]),
                .pin_in(general_pins_in[i]),
                .pin_out(general_pins_out[i]),
                .pin_oe(general_pins_oe[i]),
                .sample(sample[i])
            );
        end
    endgenerate
endmodule // gped_port

/* File: sim/gped_checker.sv */
`timescale 1ns/1ps
module gped_checker (
    input logic clk,
    input logic rst,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic wb_err_o,
    input logic [31:0] wb_dat_o,
    input logic [15:0] general_pins_out,
    input logic [15:0] general_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire an = wb_ack_o | wb_err_o;
    wire rq = wb_cyc_i & wb_stb_i & ~an;
    property p_tk; rq |=> an; endproperty
    a_tk: assert property (p_tk)
        else $error("request not answered in the next cycle");
    property p_pl; an |=> !an; endproperty
    a_pl: assert property (p_pl)
        else $error("answer lasted more than one cycle");
    property p_cz; an |-> $past(rq); endproperty
    a_cz: assert property (p_cz)
        else $error("answer without a request");
    property p_hi; wb_dat_o[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi)
        else $error("reserved read bits not zero");
    property p_er; wb_err_o |-> !wb_ack_o && wb_dat_o == 32'h0; endproperty
    a_er: assert property (p_er)
        else $error("error answer carried ack or data");
    property p_cf; $changed(general_pins_oe) |-> wb_ack_o; endproperty
    a_cf: assert property (p_cf)
        else $error("drive enable changed without a write");
    property p_dr; (general_pins_out & ~general_pins_oe) == 16'h0; endproperty
    a_dr: assert property (p_dr)
        else $error("pin driven while not an output");
    property p_rs; $fell(rst) |-> general_pins_oe == 16'h0; endproperty
    a_rs: assert property (p_rs)
        else $error("pin driven right after reset");
endmodule // gped_checker
bind gped_port gped_checker i_chk (
    .clk(clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .wb_dat_o(wb_dat_o),
    .general_pins_out(general_pins_out),
    .general_pins_oe(general_pins_oe)
);

/* File: sim/gped_board.sv */
`timescale 1ns/1ps
// a pin shows the port's drive while driven, else the board's level
module gped_board (
    input logic [15:0] drive,
    input logic [15:0] drive_en,
    input logic [15:0] level,
    output logic [15:0] pins
);
    assign pins = (drive_en & drive) | (~drive_en & level);
endmodule // gped_board

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam [31:0] A_EN = 32'h01B00000;
    localparam [31:0] A_DIR = 32'h01B00004;
    localparam [31:0] A_VAL = 32'h01B00008;
    localparam [31:0] A_OUT = 32'h01B0000C;
    localparam [31:0] A_BAD = 32'h01B00010;
    localparam [15:0] BOARD = 16'h3C5A;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [31:0] adr = 32'h00000000;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] dat;
    logic ack;
    logic err;
    logic [15:0] po;
    logic [15:0] oe;
    logic [15:0] pi;
    int n_mismatch = 0;
    int n_compared = 0;

    always #12.5 clk = ~clk;

    gped_port i_dut (
        .clk(clk),
        .rst(rst),
        .wb_cyc_i(cyc),
        .wb_stb_i(cyc),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_dat_i(wd),
        .wb_sel_i(sel),
        .wb_dat_o(dat),
        .wb_ack_o(ack),
        .wb_err_o(err),
        .general_pins_in(pi),
        .general_pins_out(po),
        .general_pins_oe(oe)
    );

    gped_board i_bd (
        .drive(po),
        .drive_en(oe),
        .level(BOARD),
        .pins(pi)
    );

    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask

    // one classic cycle; x is the error answer the address should earn
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic x);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        chk("error answer", {31'h0, x}, {31'h0, err});
        if (!w) begin
            chk("read data", d, dat);
        end
        cyc <= 1'b0;
    endtask

    task automatic test_end(input string name);
        $display("test %s ended, %0d mismatches so far", name, n_mismatch);
    endtask

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        $display("Error watchdog expected end of tests seen timeout");
        final_report;
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, A_EN, 32'h000000F9, 4'hF, 1'b0);
        bus(1'b0, A_DIR, 32'h00000000, 4'hF, 1'b0);
        chk("oe", 32'h00000000, {16'h0000, oe});
        test_end("reset values");
        bus(1'b1, A_EN, 32'hFFFF00F0, 4'hF, 1'b0);
        bus(1'b1, A_DIR, 32'hFFFF00FF, 4'hF, 1'b0);
        bus(1'b0, A_EN, 32'h000000F0, 4'hF, 1'b0);
        bus(1'b0, A_DIR, 32'h000000FF, 4'hF, 1'b0);
        chk("oe", 32'h000000F0, {16'h0000, oe});
        bus(1'b1, A_OUT, 32'h0000FFFF, 4'hF, 1'b0);
        chk("pins out", 32'h000000F0, {16'h0000, po});
        bus(1'b0, A_VAL, 32'h000000F0, 4'hF, 1'b0);
        bus(1'b1, A_DIR, 32'h0000000F, 4'hF, 1'b0);
        chk("oe", 32'h00000000, {16'h0000, oe});
        chk("pins out", 32'h00000000, {16'h0000, po});
        bus(1'b0, A_VAL, 32'h00000050, 4'hF, 1'b0);
        test_end("enable and direction");
        bus(1'b1, A_EN, 32'h0000AA55, 4'h2, 1'b0);
        bus(1'b0, A_EN, 32'h0000AAF0, 4'hF, 1'b0);
        test_end("byte lanes");
        bus(1'b1, A_BAD, 32'hFFFFFFFF, 4'hF, 1'b1);
        bus(1'b0, A_BAD, 32'h00000000, 4'hF, 1'b1);
        bus(1'b0, A_EN, 32'h0000AAF0, 4'hF, 1'b0);
        test_end("unmapped address");
        bus(1'b1, A_DIR, 32'h0000FFFF, 4'hF, 1'b0);
        chk("oe", 32'h0000AAF0, {16'h0000, oe});
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk("oe", 32'h00000000, {16'h0000, oe});
        bus(1'b0, A_EN, 32'h000000F9, 4'hF, 1'b0);
        bus(1'b0, A_DIR, 32'h00000000, 4'hF, 1'b0);
        test_end("second reset");
        final_report;
    end
endmodule // tb
